// file: timer8_defs.svh
// Register map, field positions and constants of the 8-bit compare/PWM timer.
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH
`define ADDR_MASK 8'h70
`define ADDR_FLAGS 8'h71
`define ADDR_COUNT 8'h72
`define ADDR_COMPARE 8'h73
`define ADDR_ASYNC 8'h74
`define ADDR_GENERAL 8'h75
`define ADDR_CONTROL 8'hb0
`define BIT_CMP 1
`define BIT_OVF 0
`define BIT_FORCE 7
`define BIT_EXT 4
`define BIT_SEL 3
`define BIT_HOLD 7
`define BIT_PSR 1
`define IDX_CTL 0
`define IDX_CMP 1
`define IDX_CNT 2
`define BYTE_ZERO 8'h00
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00
`define WM_NORMAL 2'h0
`define WM_PCPWM 2'h1
`define WM_CTC 2'h2
`define WM_FAST 2'h3
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3
`define COM_FLIP 2'h1
`define CS_STOP 3'h0
`define CS_DIRECT 3'h1
`define CS_DIV8 3'h2
`define CS_DIV32 3'h3
`define CS_DIV64 3'h4
`define CS_DIV128 3'h5
`define CS_DIV256 3'h6
`define PRE_ZERO 10'h000
`define PRE_ONE 10'h001
`define MASK_DIV8 10'h007
`define MASK_DIV32 10'h01f
`define MASK_DIV64 10'h03f
`define MASK_DIV128 10'h07f
`define MASK_DIV256 10'h0ff
`define MASK_DIV1024 10'h3ff
`define LOAD_EDGES 2'h2
`define EDGE_ONE 2'h1
`endif

// file: timer8_pkg.sv
// Types shared by the timer and its users.
package timer8_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic force_cmp;
    logic wave_lo;
    logic [1:0] com;
    logic wave_hi;
    logic [2:0] cs;
  } ctl_fields_t;
  typedef struct packed {
    logic out;
    logic oe;
    logic override;
  } cmp_pin_t;
endpackage

// file: async_timer8_compare_pwm.sv
// 8-bit timer with one compare channel, PWM modes and async oscillator clocking.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "timer8_defs.svh"
module async_timer8_compare_pwm
  import timer8_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire reg_req_t reg_req,
  output logic [7:0] rdata,
  input wire logic global_irq_enable,
  input wire logic compare_vector_ack,
  input wire logic overflow_vector_ack,
  input wire logic osc_pin_in,
  input wire logic pin_dir,
  output cmp_pin_t compare_out_pin,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  output logic osc_ext_buf_en,
  output logic osc_xtal_run
);
  function automatic logic tap_ok(input logic [2:0] cs, input logic [9:0] pre);
    logic [9:0] m;
    unique case (cs)
      `CS_STOP: m = `PRE_ZERO;
      `CS_DIRECT: m = `PRE_ZERO;
      `CS_DIV8: m = `MASK_DIV8;
      `CS_DIV32: m = `MASK_DIV32;
      `CS_DIV64: m = `MASK_DIV64;
      `CS_DIV128: m = `MASK_DIV128;
      `CS_DIV256: m = `MASK_DIV256;
      default: m = `MASK_DIV1024;
    endcase
    tap_ok = (cs != `CS_STOP) && ((pre & m) == m);
  endfunction

  function automatic logic apply_com(input logic cur, input logic [1:0] com);
    unique case (com)
      `COM_TOGGLE: apply_com = !cur;
      `COM_CLEAR: apply_com = 1'b0;
      `COM_SET: apply_com = 1'b1;
      default: apply_com = cur;
    endcase
  endfunction

  function automatic logic is_write(input reg_req_t r, input logic [7:0] a);
    is_write = r.wr && (r.addr == a);
  endfunction

  logic osc_s1_reg, osc_s2_reg, osc_s3_reg, osc_lvl_reg;
  logic osc_edge;
  ctl_fields_t ctl_real_reg;
  logic [7:0] temp_reg [3];
  logic [1:0] edges_reg [3];
  logic [2:0] busy_reg;
  logic [2:0] wr_idx, load;
  logic [7:0] load_val [3];
  logic [7:0] cmp_real_reg, cmp_act_reg, count_reg;
  logic up_reg, block_reg, wave_reg;
  logic [9:0] pre_reg;
  logic psr_reg, hold_reg, ext_reg, sel_reg;
  logic [1:0] irq_en_reg;
  logic cmp_flag_reg, ovf_flag_reg;
  logic cmp_irq_reg, ovf_irq_reg, ext_en_reg, xtal_reg, oe_reg, override_reg;
  logic [7:0] rdata_reg, rd_next;
  logic src_tick, tick, match, ovf_evt, top_evt, force_evt, special, pwm;
  logic [1:0] mode;
  ctl_fields_t new_ctl;

  // Synchronise oscillator pin.
  // three-stage pin filter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      osc_lvl_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_pin_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      if (osc_s2_reg == osc_s3_reg) begin
        osc_lvl_reg <= osc_s3_reg;
      end
    end
  end
  assign osc_edge = (osc_s2_reg == osc_s3_reg) && osc_s3_reg && !osc_lvl_reg;

  assign src_tick = sel_reg ? osc_edge : 1'b1;

  assign wr_idx[`IDX_CTL] = is_write(reg_req, `ADDR_CONTROL);
  assign wr_idx[`IDX_CMP] = is_write(reg_req, `ADDR_COMPARE);
  assign wr_idx[`IDX_CNT] = is_write(reg_req, `ADDR_COUNT);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      load[i] = sel_reg ? (busy_reg[i] && osc_edge && edges_reg[i] == `EDGE_ONE) : wr_idx[i];
      load_val[i] = sel_reg ? temp_reg[i] : reg_req.wdata;
    end
  end

  // Holding registers and busy flags. A write in the final edge cycle restarts the wait.
  // busy set and cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        temp_reg[i] <= `BYTE_ZERO;
        edges_reg[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_idx[i]) begin
          temp_reg[i] <= reg_req.wdata;
          busy_reg[i] <= sel_reg;
          edges_reg[i] <= 2'h0;
        end else if (busy_reg[i] && osc_edge) begin
          edges_reg[i] <= edges_reg[i] + `EDGE_ONE;
          if (edges_reg[i] == `LOAD_EDGES - `EDGE_ONE) begin
            busy_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign new_ctl = ctl_fields_t'(load_val[`IDX_CTL]);
  assign mode = {ctl_real_reg.wave_hi, ctl_real_reg.wave_lo};
  assign pwm = (mode == `WM_PCPWM) || (mode == `WM_FAST);
  assign force_evt = load[`IDX_CTL] && new_ctl.force_cmp && !new_ctl.wave_lo;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_real_reg <= ctl_fields_t'(`BYTE_ZERO);
      cmp_real_reg <= `BYTE_ZERO;
    end else begin
      if (load[`IDX_CTL]) begin
        ctl_real_reg <= new_ctl;
        ctl_real_reg.force_cmp <= 1'b0;
      end
      if (load[`IDX_CMP]) begin
        cmp_real_reg <= load_val[`IDX_CMP];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= `PRE_ZERO;
      psr_reg <= 1'b0;
    end else begin
      if (psr_reg && src_tick) begin
        pre_reg <= `PRE_ZERO;
      end else if (src_tick) begin
        pre_reg <= pre_reg + `PRE_ONE;
      end
      if (is_write(reg_req, `ADDR_GENERAL) && reg_req.wdata[`BIT_PSR]) begin
        psr_reg <= 1'b1;
      end else if (psr_reg && src_tick && !hold_reg) begin
        psr_reg <= 1'b0;
      end
    end
  end

  assign tick = src_tick && !psr_reg && tap_ok(ctl_real_reg.cs, pre_reg);
  assign match = tick && (count_reg == cmp_act_reg) && !block_reg;
  assign ovf_evt = tick && ((mode == `WM_PCPWM) ? (!up_reg && count_reg == `CNT_BOTTOM) : count_reg == `CNT_MAX);
  assign top_evt = tick && (count_reg == `CNT_MAX);
  assign special = pwm && (cmp_act_reg == `CNT_MAX) && ctl_real_reg.com[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= `CNT_BOTTOM;
      up_reg <= 1'b1;
      block_reg <= 1'b0;
      cmp_act_reg <= `BYTE_ZERO;
    end else begin
      if (load[`IDX_CNT]) begin
        count_reg <= load_val[`IDX_CNT];
      end else if (tick) begin
        unique case (mode)
          `WM_PCPWM: begin
            if (up_reg ? (count_reg == `CNT_MAX) : (count_reg != `CNT_BOTTOM)) begin
              count_reg <= count_reg - 8'h01;
              up_reg <= 1'b0;
            end else begin
              count_reg <= count_reg + 8'h01;
              up_reg <= 1'b1;
            end
          end
          // no clear on force
          // Only a real match clears in clear-on-match mode, so a forced strobe cannot.
          `WM_CTC: count_reg <= match ? `CNT_BOTTOM : count_reg + 8'h01;
          default: count_reg <= count_reg + 8'h01;
        endcase
      end
      if (load[`IDX_CNT]) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
      if (!pwm || top_evt) begin
        cmp_act_reg <= cmp_real_reg;
      end
    end
  end

  // Waveform output. Reserved value 1 in PWM modes leaves the output alone.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wave_reg <= 1'b0;
    end else if (force_evt) begin
      wave_reg <= apply_com(wave_reg, new_ctl.com);
    end else if (!pwm) begin
      if (match) begin
        wave_reg <= apply_com(wave_reg, ctl_real_reg.com);
      end
    end else if (ctl_real_reg.com[1]) begin
      if (mode == `WM_FAST) begin
        if (top_evt) begin
          wave_reg <= apply_com(wave_reg, ctl_real_reg.com ^ `COM_FLIP);
        end else if (match && !special) begin
          wave_reg <= apply_com(wave_reg, ctl_real_reg.com);
        end
      end else if (special) begin
        if (top_evt) begin
          wave_reg <= apply_com(wave_reg, ctl_real_reg.com ^ `COM_FLIP);
        end
      end else if (match) begin
        wave_reg <= apply_com(wave_reg, up_reg ? ctl_real_reg.com : ctl_real_reg.com ^ `COM_FLIP);
      end
    end
  end

  // Flags: hardware set wins over a same-cycle clear.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
    end else begin
      if (match) begin
        cmp_flag_reg <= 1'b1;
      end else if (compare_vector_ack || (is_write(reg_req, `ADDR_FLAGS) && reg_req.wdata[`BIT_CMP])) begin
        cmp_flag_reg <= 1'b0;
      end
      if (ovf_evt) begin
        ovf_flag_reg <= 1'b1;
      end else if (overflow_vector_ack || (is_write(reg_req, `ADDR_FLAGS) && reg_req.wdata[`BIT_OVF])) begin
        ovf_flag_reg <= 1'b0;
      end
    end
  end

  // Control bits and registered outputs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_reg <= 2'h0;
      ext_reg <= 1'b0;
      sel_reg <= 1'b0;
      hold_reg <= 1'b0;
      cmp_irq_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      xtal_reg <= 1'b1;
      oe_reg <= 1'b0;
      override_reg <= 1'b0;
    end else begin
      if (is_write(reg_req, `ADDR_MASK)) begin
        irq_en_reg <= reg_req.wdata[1:0];
      end
      if (is_write(reg_req, `ADDR_ASYNC)) begin
        ext_reg <= reg_req.wdata[`BIT_EXT];
        sel_reg <= reg_req.wdata[`BIT_SEL];
      end
      if (is_write(reg_req, `ADDR_GENERAL)) begin
        hold_reg <= reg_req.wdata[`BIT_HOLD];
      end
      cmp_irq_reg <= cmp_flag_reg && irq_en_reg[`BIT_CMP] && global_irq_enable;
      ovf_irq_reg <= ovf_flag_reg && irq_en_reg[`BIT_OVF] && global_irq_enable;
      ext_en_reg <= ext_reg && sel_reg;
      xtal_reg <= !ext_reg;
      override_reg <= ctl_real_reg.com != `COM_OFF;
      oe_reg <= (ctl_real_reg.com != `COM_OFF) && pin_dir;
    end
  end

  always_comb begin
    rd_next = `BYTE_ZERO;
    unique case (reg_req.addr)
      `ADDR_MASK: rd_next[1:0] = irq_en_reg;
      `ADDR_FLAGS: begin
        rd_next[`BIT_CMP] = cmp_flag_reg;
        rd_next[`BIT_OVF] = ovf_flag_reg;
      end
      `ADDR_COUNT: rd_next = count_reg;
      `ADDR_COMPARE: rd_next = temp_reg[`IDX_CMP];
      `ADDR_CONTROL: begin
        rd_next = temp_reg[`IDX_CTL];
        rd_next[`BIT_FORCE] = 1'b0;
      end
      `ADDR_ASYNC: begin
        rd_next[2:0] = busy_reg;
        rd_next[`BIT_EXT] = ext_reg;
        rd_next[`BIT_SEL] = sel_reg;
      end
      `ADDR_GENERAL: begin
        rd_next[`BIT_HOLD] = hold_reg;
        rd_next[`BIT_PSR] = psr_reg;
      end
      default: rd_next = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= `BYTE_ZERO;
    end else begin
      rdata_reg <= reg_req.rd ? rd_next : `BYTE_ZERO;
    end
  end

  assign rdata = rdata_reg;
  assign compare_irq_req = cmp_irq_reg;
  assign overflow_irq_req = ovf_irq_reg;
  assign osc_ext_buf_en = ext_en_reg;
  assign osc_xtal_run = xtal_reg;
  assign compare_out_pin = '{out: wave_reg, oe: oe_reg, override: override_reg};

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_async_write(i);
    sel_reg && wr_idx[i];
  endsequence

  property p_force_no_flag;
    force_evt && !match && !cmp_flag_reg |=> !cmp_flag_reg;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("forced strobe set the flag");

  property p_ctl_read_zero;
    reg_req.rd && reg_req.addr == `ADDR_CONTROL |=> !rdata[`BIT_FORCE];
  endproperty
  a_ctl_read_zero: assert property (p_ctl_read_zero) else $error("strobe bit read as one");

  property p_override;
    ##1 compare_out_pin.override == ($past(ctl_real_reg.com) != `COM_OFF);
  endproperty
  a_override: assert property (p_override) else $error("pin override wrong");

  property p_toggle;
    match && !force_evt && mode == `WM_NORMAL && ctl_real_reg.com == `COM_TOGGLE |=> wave_reg != $past(wave_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match missing");

  property p_count_write;
    !sel_reg && wr_idx[`IDX_CNT] |=> count_reg == $past(reg_req.wdata) && block_reg;
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write not applied");

  property p_match_flag;
    match |=> cmp_flag_reg ##1 cmp_irq_reg || !irq_en_reg[`BIT_CMP] || !global_irq_enable;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not flag");

  property p_irq;
    cmp_flag_reg && irq_en_reg[`BIT_CMP] && global_irq_enable |=> compare_irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("compare request missing");

  property p_busy_set;
    s_async_write(`IDX_CMP) |=> busy_reg[`IDX_CMP] && edges_reg[`IDX_CMP] == 2'h0;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set on async write");

  property p_busy_clear;
    $fell(busy_reg[`IDX_CNT]) |-> $past(osc_edge) && $past(edges_reg[`IDX_CNT]) == `EDGE_ONE;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy cleared early");

  property p_psr_sync;
    !sel_reg && !hold_reg && is_write(reg_req, `ADDR_GENERAL) && reg_req.wdata[`BIT_PSR]
      && !reg_req.wdata[`BIT_HOLD] |=> psr_reg ##1 !psr_reg && pre_reg == `PRE_ZERO;
  endproperty
  a_psr_sync: assert property (p_psr_sync) else $error("prescaler reset not immediate");
endmodule

// file: tb_async_timer8_compare_pwm.sv
// Self-checking testbench for the 8-bit compare/PWM timer.
`timescale 1ns/1ps
`include "timer8_defs.svh"
module tb_async_timer8_compare_pwm import timer8_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] rdata;
  logic global_irq_enable = 1'b0;
  logic compare_vector_ack = 1'b0;
  logic overflow_vector_ack = 1'b0;
  logic osc_pin_in = 1'b0;
  logic pin_dir = 1'b1;
  logic osc_run = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  cmp_pin_t compare_out_pin;
  logic compare_irq_req, overflow_irq_req, osc_ext_buf_en, osc_xtal_run;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] rd_val;

  async_timer8_compare_pwm async_timer8_compare_pwm_i (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .rdata(rdata),
    .global_irq_enable(global_irq_enable), .compare_vector_ack(compare_vector_ack),
    .overflow_vector_ack(overflow_vector_ack), .osc_pin_in(osc_pin_in), .pin_dir(pin_dir),
    .compare_out_pin(compare_out_pin), .compare_irq_req(compare_irq_req),
    .overflow_irq_req(overflow_irq_req), .osc_ext_buf_en(osc_ext_buf_en), .osc_xtal_run(osc_xtal_run)
  );

  always #10 clk = ~clk;

  // The crystal runs freely once enabled; each phase lasts five system clocks.
  always @(posedge clk) begin
    if (osc_run) begin
      osc_cnt <= osc_cnt + 3'h1;
      if (osc_cnt == 3'h4) begin
        osc_cnt <= 3'h0;
        osc_pin_in <= ~osc_pin_in;
      end
    end
  end

  function automatic logic [7:0] ctl(input logic f, input logic [1:0] m, input logic [1:0] c,
                                     input logic [2:0] s);
    return {f, m[0], c, m[1], s};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t count %h outside %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    rd(a);
    chk8(rd_val & m, exp, "register read");
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [7:0] addrs [8] = '{`ADDR_MASK, `ADDR_FLAGS, `ADDR_COUNT, `ADDR_COMPARE, `ADDR_ASYNC,
                              `ADDR_GENERAL, `ADDR_CONTROL, 8'h7f};
    chk8({5'h00, compare_out_pin}, 8'h00, "pin after reset");
    chk8({6'h00, osc_ext_buf_en, osc_xtal_run}, 8'h01, "oscillator after reset");
    for (int i = 0; i < 8; i++) begin
      chk_reg(addrs[i], 8'hff, 8'h00);
    end
    wr(8'h7f, 8'hff);
    chk_reg(8'h7f, 8'hff, 8'h00);
    wr(`ADDR_MASK, 8'hff);
    chk_reg(`ADDR_MASK, 8'hff, 8'h03);
    wr(`ADDR_GENERAL, 8'h02);
    chk_reg(`ADDR_GENERAL, 8'hff, 8'h00);
    wr(`ADDR_GENERAL, 8'h82);
    chk_reg(`ADDR_GENERAL, 8'hff, 8'h82);
    wr(`ADDR_GENERAL, 8'h00);
    $display("done: reset and map");
  endtask

  task automatic t_force();
    logic [1:0] coms [4] = '{`COM_SET, `COM_CLEAR, `COM_TOGGLE, `COM_TOGGLE};
    logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CONTROL, ctl(1'b1, `WM_NORMAL, coms[i], `CS_STOP));
      settle();
      chk8({7'h00, compare_out_pin.out}, {7'h00, exps[i]}, "forced level");
    end
    chk8({6'h00, compare_out_pin.oe, compare_out_pin.override}, 8'h03, "pin takeover");
    chk_reg(`ADDR_CONTROL, 8'hff, 8'h10);
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h00);
    chk8({6'h00, compare_irq_req, overflow_irq_req}, 8'h00, "forced irq");
    wr(`ADDR_CONTROL, ctl(1'b1, `WM_FAST, `COM_SET, `CS_STOP));
    settle();
    chk8({7'h00, compare_out_pin.out}, 8'h00, "force in fast pwm");
    wr(`ADDR_CONTROL, ctl(1'b1, `WM_PCPWM, `COM_SET, `CS_STOP));
    settle();
    chk8({7'h00, compare_out_pin.out}, 8'h00, "force in phase pwm");
    @(posedge clk);
    pin_dir <= 1'b0;
    settle();
    chk8({6'h00, compare_out_pin.oe, compare_out_pin.override}, 8'h01, "driver off");
    pin_dir <= 1'b1;
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_STOP));
    settle();
    chk8({7'h00, compare_out_pin.override}, 8'h00, "pin released");
    $display("done: force strobe");
  endtask

  task automatic t_match();
    @(posedge clk);
    global_irq_enable <= 1'b1;
    wr(`ADDR_COMPARE, 8'h20);
    wr(`ADDR_COUNT, 8'h1a);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_TOGGLE, `CS_DIRECT));
    repeat (12) @(posedge clk);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_TOGGLE, `CS_STOP));
    settle();
    chk8({7'h00, compare_out_pin.out}, 8'h01, "toggle on match");
    chk8({6'h00, compare_irq_req, overflow_irq_req}, 8'h02, "compare irq");
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h02);
    global_irq_enable <= 1'b0;
    settle();
    chk8({7'h00, compare_irq_req}, 8'h00, "global gate");
    global_irq_enable <= 1'b1;
    wr(`ADDR_FLAGS, 8'h00);
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h02);
    compare_vector_ack <= 1'b1;
    @(posedge clk);
    compare_vector_ack <= 1'b0;
    settle();
    chk8({7'h00, compare_irq_req}, 8'h00, "irq after vector");
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h00);
    wr(`ADDR_COUNT, 8'hfc);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_DIRECT));
    repeat (10) @(posedge clk);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_STOP));
    settle();
    chk8({7'h00, overflow_irq_req}, 8'h01, "overflow irq");
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h01);
    wr(`ADDR_FLAGS, 8'h01);
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h00);
    wr(`ADDR_COMPARE, 8'h40);
    wr(`ADDR_COUNT, 8'h80);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_DIRECT));
    wr(`ADDR_COUNT, 8'h40);
    repeat (20) @(posedge clk);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_STOP));
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h00);
    $display("done: match and flags");
  endtask

  task automatic t_ctc();
    wr(`ADDR_COMPARE, 8'h05);
    wr(`ADDR_COUNT, 8'h00);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_CTC, `COM_OFF, `CS_DIRECT));
    repeat (40) @(posedge clk);
    wr(`ADDR_CONTROL, ctl(1'b0, `WM_CTC, `COM_OFF, `CS_STOP));
    rd(`ADDR_COUNT);
    chk_rng(rd_val, 8'h00, 8'h05);
    chk_reg(`ADDR_FLAGS, 8'h02, 8'h02);
    wr(`ADDR_FLAGS, 8'h03);
    wr(`ADDR_COMPARE, 8'h40);
    wr(`ADDR_COUNT, 8'h33);
    wr(`ADDR_CONTROL, ctl(1'b1, `WM_CTC, `COM_OFF, `CS_STOP));
    settle();
    chk_reg(`ADDR_COUNT, 8'hff, 8'h33);
    chk_reg(`ADDR_FLAGS, 8'hff, 8'h00);
    $display("done: clear on match");
  endtask

  // Prescaler phase is unknown at the start, so one tick below and three ticks above the expected count are allowed.
  task automatic t_prescale();
    int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
    int k;
    for (int i = 0; i < 7; i++) begin
      k = (divs[i] == 1024) ? 4 : 20;
      wr(`ADDR_COUNT, 8'h00);
      wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, 3'(i + 1)));
      repeat (k * divs[i]) @(posedge clk);
      wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_STOP));
      rd(`ADDR_COUNT);
      chk_rng(rd_val, 8'(k - 1), 8'(k + 3));
    end
    k = rd_val;
    repeat (50) @(posedge clk);
    chk_reg(`ADDR_COUNT, 8'hff, 8'(k));
    $display("done: clock select");
  endtask

  // Compare at mid scale: the frozen level follows from the frozen count.
  task automatic t_pwm();
    logic [1:0] modes [2] = '{`WM_FAST, `WM_PCPWM};
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_CONTROL, ctl(1'b0, `WM_NORMAL, `COM_OFF, `CS_STOP));
      wr(`ADDR_COMPARE, 8'h80);
      wr(`ADDR_CONTROL, ctl(1'b0, modes[i], `COM_CLEAR, `CS_DIRECT));
      repeat (1200) @(posedge clk);
      wr(`ADDR_CONTROL, ctl(1'b0, modes[i], `COM_CLEAR, `CS_STOP));
      rd(`ADDR_COUNT);
      chk8({7'h00, compare_out_pin.out}, {7'h00, (rd_val < 8'h80) || (rd_val == 8'h80 && i == 0)}, "pwm level");
    end
    $display("done: pwm modes");
  endtask

  task automatic t_async();
    logic [7:0] ad [3] = '{`ADDR_CONTROL, `ADDR_COMPARE, `ADDR_COUNT};
    logic [7:0] vals [3] = '{8'h10, 8'h44, 8'h55};
    int n;
    logic [7:0] cnt0;
    osc_run <= 1'b1;
    wr(`ADDR_ASYNC, 8'h10);
    settle();
    chk8({6'h00, osc_ext_buf_en, osc_xtal_run}, 8'h00, "ext enable only");
    wr(`ADDR_ASYNC, 8'h18);
    settle();
    chk8({6'h00, osc_ext_buf_en, osc_xtal_run}, 8'h02, "ext clock on");
    chk_reg(`ADDR_ASYNC, 8'hff, 8'h18);
    rd(`ADDR_COUNT);
    cnt0 = rd_val;
    for (int i = 0; i < 3; i++) begin
      wr(ad[i], vals[i]);
      chk_reg(`ADDR_ASYNC, 8'h07, 8'(1 << i));
      chk_reg(ad[i], 8'hff, (i == 2) ? cnt0 : vals[i]);
      n = 0;
      do begin
        rd(`ADDR_ASYNC);
        n++;
      end while (rd_val[i] !== 1'b0 && n < 50);
      chk8(rd_val & 8'h07, 8'h00, "busy cleared");
      chk_reg(ad[i], 8'hff, vals[i]);
    end
    chk8({7'h00, compare_out_pin.override}, 8'h01, "loaded control");
    $display("done: async writes");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_force();
    t_match();
    t_ctc();
    t_prescale();
    t_pwm();
    t_async();
    complete_run();
  end

  // The full sequence takes roughly 17 thousand cycles; this leaves wide margin.
  initial begin
    #1000000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
